// [include/cmp_ctrl_pkg.sv]
/*
 Constants for the comparator control block: register offsets, bit positions,
 reset values and event-select encodings.
 Assumes an 8-bit register port driven by the core clock.
*/
package cmp_ctrl_pkg;
    localparam logic [1:0] OFS_CONV_B = 2'h0;
    localparam logic [1:0] OFS_CMP_CS = 2'h1;
    localparam logic [1:0] OFS_DIS = 2'h2;
    localparam int ADDR_W = 2;
    localparam int BIT_MUXUSE = 6;
    localparam int BIT_PWROFF = 7;
    localparam int BIT_REFSEL = 6;
    localparam int BIT_RESULT = 5;
    localparam int BIT_FLAG = 4;
    localparam int BIT_IEN = 3;
    localparam int BIT_NEG_OFF = 1;
    localparam int BIT_POS_OFF = 0;
    localparam logic [7:0] CONV_B_WMASK = 8'h47;
    localparam logic [7:0] DIS_WMASK = 8'h3F;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] EVT_TOGGLE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h2;
    localparam logic [1:0] EVT_RISE = 2'h3;
    localparam logic [1:0] NEG_SEL_PIN = 2'h0;
    localparam int EVT_LSB = 0;
    localparam int EVT_W = 2;
    localparam int BIT_RSVD = 2;
    localparam logic [1:0] EVT_RESERVED = 2'h1;
endpackage

// [rtl/cmp_ctrl.sv]
/*
 Comparator control: input selection, result synchronizer, event detection,
 event flag, interrupt request and pin buffer disables.
 Assumes the analog comparator output arrives asynchronously on CMP_RAW.
*/
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic CONVERTER_ON,
    input wire logic [1:0] CHANNEL_SELECT_LOW,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    input wire logic CMP_RAW,
    input wire logic POS_PIN_DIN,
    input wire logic NEG_PIN_DIN,
    output logic COMPARATOR_POWER_OFF,
    output logic POS_SEL_INTERNAL_REF,
    output logic NEG_SEL_MUX,
    output logic [1:0] NEG_CHANNEL,
    output logic POS_PIN_BUFFER_OFF,
    output logic NEG_PIN_BUFFER_OFF,
    output logic POS_PIN_IN,
    output logic NEG_PIN_IN,
    output logic COMPARE_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] conv_b;
    logic [7:0] dis;
    logic power_off;
    logic ref_on_pos;
    logic irq_en;
    logic [1:0] evt_sel;
    logic evt_flag;
    logic compare_result;
    logic result_prev;
    logic event_pulse;
    logic wr_conv_b;
    logic wr_cs;
    logic wr_dis;
    logic [7:0] next_rdata;
    logic pos_sync;
    logic neg_sync;

    assign wr_conv_b = WR && (ADDR == OFS_CONV_B);
    assign wr_cs = WR && (ADDR == OFS_CMP_CS);
    assign wr_dis = WR && (ADDR == OFS_DIS);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            conv_b <= RST_BYTE;
        end else if (wr_conv_b) begin
            conv_b <= WDATA & CONV_B_WMASK;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            dis <= RST_BYTE;
        end else if (wr_dis) begin
            dis <= WDATA & DIS_WMASK;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            power_off <= 1'b0;
            ref_on_pos <= 1'b0;
            irq_en <= 1'b0;
            evt_sel <= EVT_TOGGLE;
        end else if (wr_cs) begin
            power_off <= WDATA[BIT_PWROFF];
            ref_on_pos <= WDATA[BIT_REFSEL];
            irq_en <= WDATA[BIT_IEN];
            evt_sel <= WDATA[EVT_LSB +: EVT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input selection
    assign COMPARATOR_POWER_OFF = power_off;
    assign POS_SEL_INTERNAL_REF = ref_on_pos;
    assign NEG_SEL_MUX = conv_b[BIT_MUXUSE] && !CONVERTER_ON;
    assign NEG_CHANNEL = NEG_SEL_MUX ? CHANNEL_SELECT_LOW : NEG_SEL_PIN;

    ////////////////////////////////////////////////////////////////////////
    // Result synchronizer and event detection
    cmp_sync u_result_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d(CMP_RAW),
        .q(compare_result)
    );

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            result_prev <= 1'b0;
        end else begin
            result_prev <= compare_result;
        end
    end

    always_comb begin
        case (evt_sel)
            EVT_TOGGLE: event_pulse = compare_result ^ result_prev;
            EVT_FALL: event_pulse = !compare_result && result_prev;
            EVT_RISE: event_pulse = compare_result && !result_prev;
            default: event_pulse = 1'b0;
        endcase
    end

    // Set wins over any clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            evt_flag <= 1'b0;
        end else if (event_pulse) begin
            evt_flag <= 1'b1;
        end else if (IRQ_ACK) begin
            evt_flag <= 1'b0;
        end else if (wr_cs && WDATA[BIT_FLAG]) begin
            evt_flag <= 1'b0;
        end
    end

    assign COMPARE_IRQ = evt_flag && irq_en && GLOBAL_IRQ_EN;

    ////////////////////////////////////////////////////////////////////////
    // Pin digital input buffers
    cmp_sync u_pos_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d(POS_PIN_DIN),
        .q(pos_sync)
    );

    cmp_sync u_neg_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d(NEG_PIN_DIN),
        .q(neg_sync)
    );

    assign POS_PIN_BUFFER_OFF = dis[BIT_POS_OFF];
    assign NEG_PIN_BUFFER_OFF = dis[BIT_NEG_OFF];

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            POS_PIN_IN <= 1'b0;
            NEG_PIN_IN <= 1'b0;
        end else begin
            POS_PIN_IN <= pos_sync && !dis[BIT_POS_OFF];
            NEG_PIN_IN <= neg_sync && !dis[BIT_NEG_OFF];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_comb begin
        next_rdata = RST_BYTE;
        if (ADDR == OFS_CONV_B) begin
            next_rdata = conv_b;
        end else if (ADDR == OFS_CMP_CS) begin
            next_rdata = {power_off, ref_on_pos, compare_result, evt_flag,
                          irq_en, 1'b0, evt_sel};
        end else if (ADDR == OFS_DIS) begin
            next_rdata = dis;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RDATA <= RST_BYTE;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_flag_set_event: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        event_pulse |=> evt_flag)
        else $error("event flag not set after event");

    a_flag_write_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_cs && WDATA[BIT_FLAG] && !event_pulse) |=> !evt_flag)
        else $error("event flag not cleared by write one");

    a_flag_ack_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (IRQ_ACK && !event_pulse) |=> !evt_flag)
        else $error("event flag not cleared by vector");

    a_flag_zero_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_flag && wr_cs && !WDATA[BIT_FLAG] && !IRQ_ACK) |=> evt_flag)
        else $error("writing zero changed event flag");

    a_irq_gating: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_cs && !WDATA[BIT_IEN]) |=> !COMPARE_IRQ)
        else $error("interrupt request with enable cleared");

    a_result_delay: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(compare_result) |-> $past(CMP_RAW, 2))
        else $error("result not two stages behind raw output");

    a_rise_detect: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_sel == EVT_RISE && $rose(compare_result)) |=> evt_flag)
        else $error("rising edge missed");

    a_fall_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_sel == EVT_FALL && $rose(compare_result) && !evt_flag) |=> !evt_flag)
        else $error("falling select fired on other transition");

    a_neg_mux: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CONVERTER_ON |-> !NEG_SEL_MUX)
        else $error("mux used while converter on");

    a_pin_forced: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        dis[BIT_POS_OFF] |=> !POS_PIN_IN)
        else $error("disabled pin input not zero");

    a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (RD && ADDR == OFS_CMP_CS) |=> !RDATA[BIT_RSVD])
        else $error("reserved bit read as one");

    // Event decode, flag hold, result synchronizer and result/flag read-back
    a_toggle_detect: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_sel == EVT_TOGGLE && $changed(compare_result)) |=> evt_flag)
        else $error("toggle missed");

    a_fall_detect: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_sel == EVT_FALL && $fell(compare_result)) |=> evt_flag)
        else $error("falling edge missed");

    a_rise_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_sel == EVT_RISE && $fell(compare_result) && !evt_flag) |=> !evt_flag)
        else $error("rising select fired on falling edge");

    a_reserved_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_sel == EVT_RESERVED && !evt_flag) |=> !evt_flag)
        else $error("reserved select raised the flag");

    a_flag_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (evt_flag && !wr_cs && !IRQ_ACK) |=> evt_flag)
        else $error("event flag dropped without a clear");

    a_result_fall: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $fell(compare_result) |-> !$past(CMP_RAW, 2))
        else $error("result fell out of step with raw output");

    a_result_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (RD && ADDR == OFS_CMP_CS) |=> (RDATA[BIT_RESULT] == $past(compare_result)))
        else $error("result bit read wrong");

    a_flag_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (RD && ADDR == OFS_CMP_CS) |=> (RDATA[BIT_FLAG] == $past(evt_flag)))
        else $error("flag bit read wrong");

    // Interrupt request
    a_irq_global: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !GLOBAL_IRQ_EN |-> !COMPARE_IRQ)
        else $error("interrupt request without global enable");

    a_ien_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wr_cs |=> (irq_en == $past(WDATA[BIT_IEN])))
        else $error("interrupt enable not written");

    // Input selection and pins
    a_power_off_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wr_cs |=> (COMPARATOR_POWER_OFF == $past(WDATA[BIT_PWROFF])))
        else $error("power-off bit not applied");

    a_ref_select_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wr_cs |=> (POS_SEL_INTERNAL_REF == $past(WDATA[BIT_REFSEL])))
        else $error("reference select not applied");

    a_mux_channel: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (conv_b[BIT_MUXUSE] && !CONVERTER_ON) |->
            (NEG_SEL_MUX && NEG_CHANNEL == CHANNEL_SELECT_LOW))
        else $error("channel not routed to negative input");

    a_neg_pin_default: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !conv_b[BIT_MUXUSE] |-> (!NEG_SEL_MUX && NEG_CHANNEL == NEG_SEL_PIN))
        else $error("negative pin not selected with mux bit clear");

    a_channel_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !NEG_SEL_MUX |-> (NEG_CHANNEL == NEG_SEL_PIN))
        else $error("channel code not idle while pin selected");

    a_neg_forced: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        dis[BIT_NEG_OFF] |=> !NEG_PIN_IN)
        else $error("disabled negative pin input not zero");

    a_pos_pin_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !dis[BIT_POS_OFF] |=> (POS_PIN_IN == $past(pos_sync)))
        else $error("enabled positive pin input not passed");

    a_neg_pin_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !dis[BIT_NEG_OFF] |=> (NEG_PIN_IN == $past(neg_sync)))
        else $error("enabled negative pin input not passed");

    a_dis_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        wr_dis |=> ({NEG_PIN_BUFFER_OFF, POS_PIN_BUFFER_OFF} ==
            $past({WDATA[BIT_NEG_OFF], WDATA[BIT_POS_OFF]})))
        else $error("buffer disable bits not applied");

endmodule

// [rtl/cmp_sync.sv]
/*
 Two-flop synchronizer for one level.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module cmp_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// [verif/cmp_analog_model.sv]
/*
 Far-side model: input pins, converter channels and internal reference feeding
 the analog comparator, producing its raw output from the selected inputs.
 Assumes the selection outputs of the comparator control block drive it.
*/
`timescale 1ns/1ps
module cmp_analog_model (
    input wire logic power_off,
    input wire logic sel_ref,
    input wire logic sel_mux,
    input wire logic [1:0] channel,
    input int pos_mv,
    input int neg_mv,
    input int ref_mv,
    input int ch_mv [4],
    output logic cmp_out
);
    int pos_in;
    int neg_in;
    always_comb begin
        pos_in = sel_ref ? ref_mv : pos_mv;
        neg_in = sel_mux ? ch_mv[channel] : neg_mv;
        // A powered-down comparator drives its output low
        cmp_out = power_off ? 1'b0 : (pos_in > neg_in);
    end
endmodule

// [verif/tb_top.sv]
/*
 Self-checking bench for the comparator control block.
 Assumes a single 200 MHz core clock and the analog far-side model.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tb_top;
    import cmp_ctrl_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, conv_on = 0, gie = 0, ack = 0;
    logic pos_din = 0, neg_din = 0, raw, pwr, refsel, selmux, pbo, nbo, pin_p, pin_n, irq;
    logic rd_seen = 0;
    logic [1:0] addr = 0, chsel = 0, nch;
    logic [7:0] wdata = 0, rdata, exp_rd;
    logic [31:0] lfsr = 32'h0C79;
    int fails = 0, num_checks = 0, pos_mv = 100, neg_mv = 200, ref_mv = 50;
    int ch_mv [4] = '{10, 20, 30, 40};
    logic [7:0] exp_q [$];
    cmp_ctrl cmp_ctrl_inst (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .CONVERTER_ON(conv_on), .CHANNEL_SELECT_LOW(chsel),
        .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack), .CMP_RAW(raw), .POS_PIN_DIN(pos_din),
        .NEG_PIN_DIN(neg_din), .COMPARATOR_POWER_OFF(pwr), .POS_SEL_INTERNAL_REF(refsel),
        .NEG_SEL_MUX(selmux), .NEG_CHANNEL(nch), .POS_PIN_BUFFER_OFF(pbo),
        .NEG_PIN_BUFFER_OFF(nbo), .POS_PIN_IN(pin_p), .NEG_PIN_IN(pin_n), .COMPARE_IRQ(irq));
    cmp_analog_model cmp_analog_model_inst (.power_off(pwr), .sel_ref(refsel),
        .sel_mux(selmux), .channel(nch), .pos_mv(pos_mv), .neg_mv(neg_mv), .ref_mv(ref_mv),
        .ch_mv(ch_mv), .cmp_out(raw));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Read data stands only in the cycle after the read strobe
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen) begin
            exp_rd = exp_q.pop_front();
            `CHK(rdata, exp_rd)
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++) rd_reg(a[1:0], RST_BYTE);
        wr_reg(OFS_CONV_B, 8'hFF);
        wr_reg(2'h3, 8'hFF);
        rd_reg(OFS_CONV_B, CONV_B_WMASK);
        rd_reg(2'h3, 8'h00);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            chsel <= c[1:0];
            settle(1);
            `CHK(selmux, 1'b1)
            `CHK(nch, c[1:0])
        end
        @(posedge clk);
        conv_on <= 1'b1;
        settle(1);
        `CHK(selmux, 1'b0)
        @(posedge clk);
        conv_on <= 1'b0;
        wr_reg(OFS_CONV_B, 8'h00);
        settle(1);
        `CHK(selmux, 1'b0)
        // The selection changes above toggled the result, so the flag is set
        wr_reg(OFS_CMP_CS, 8'hC4);
        settle(1);
        `CHK({pwr, refsel}, 2'b11)
        rd_reg(OFS_CMP_CS, 8'hD0);
        wr_reg(OFS_CMP_CS, 8'h10);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            wr_reg(OFS_DIS, lfsr[7:0]);
            rd_reg(OFS_DIS, lfsr[7:0] & DIS_WMASK);
            settle(1);
            `CHK({nbo, pbo}, lfsr[1:0])
        end
        wr_reg(OFS_DIS, 8'h00);
        pos_din <= 1'b1;
        neg_din <= 1'b1;
        settle(5);
        `CHK({pin_n, pin_p}, 2'b11)
        wr_reg(OFS_DIS, 8'h03);
        settle(4);
        `CHK({pin_n, pin_p}, 2'b00)
        for (int m = 0; m < 4; m++) begin
            wr_reg(OFS_CMP_CS, 8'h10 | m[1:0]);
            pos_mv <= 300;
            settle(5);
            rd_reg(OFS_CMP_CS, 8'h20 | m[1:0] | ((m == 0 || m == 3) ? 8'h10 : 8'h00));
            wr_reg(OFS_CMP_CS, 8'h10 | m[1:0]);
            rd_reg(OFS_CMP_CS, 8'h20 | m[1:0]);
            pos_mv <= 100;
            settle(5);
            rd_reg(OFS_CMP_CS, m[1:0] | ((m == 0 || m == 2) ? 8'h10 : 8'h00));
        end
        wr_reg(OFS_CMP_CS, 8'h13);
        pos_mv <= 300;
        settle(5);
        wr_reg(OFS_CMP_CS, 8'h0B);
        rd_reg(OFS_CMP_CS, 8'h3B);
        settle(1);
        `CHK(irq, 1'b0)
        @(posedge clk);
        gie <= 1'b1;
        settle(1);
        `CHK(irq, 1'b1)
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        settle(1);
        `CHK(irq, 1'b0)
        rd_reg(OFS_CMP_CS, 8'h2B);
        // Reset in mid-run returns the registers to their idle values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_DIS, RST_BYTE);
        settle(1);
        `CHK(irq, 1'b0)
        settle(2);
        end_of_test();
    end
endmodule
